// >>> inc/cic_pkg.sv
/*
 * Constants for the core interrupt control block: register indices, field positions,
 * reset values, vector addresses and read/write masks.
 * Assumes a classic Wishbone bus with 32-bit data; each register takes one aligned word.
 */
package cic_pkg;

	// Register word offsets, in bytes.
	localparam logic [3:0] OFS_MAIN = 4'h0;
	localparam logic [3:0] OFS_EDGE_PRIO = 4'h4;
	localparam logic [3:0] OFS_EXT_PINS = 4'h8;
	localparam logic [3:0] OFS_CONFIG = 4'hC;

	// Main register fields.
	localparam int MAIN_GHE = 7;
	localparam int MAIN_PLE = 6;
	localparam int MAIN_T0_EN = 5;
	localparam int MAIN_X0_EN = 4;
	localparam int MAIN_PC_EN = 3;
	localparam int MAIN_T0_FLAG = 2;
	localparam int MAIN_X0_FLAG = 1;
	localparam int MAIN_PC_FLAG = 0;

	// Edge and priority register fields.
	localparam int EP_PULLUP_DIS = 7;
	localparam int EP_X0_EDGE = 6;
	localparam int EP_X1_EDGE = 5;
	localparam int EP_X2_EDGE = 4;
	localparam int EP_T0_PRIO = 2;
	localparam int EP_PC_PRIO = 0;

	// External pins register fields.
	localparam int XP_X2_PRIO = 7;
	localparam int XP_X1_PRIO = 6;
	localparam int XP_X2_EN = 4;
	localparam int XP_X1_EN = 3;
	localparam int XP_X2_FLAG = 1;
	localparam int XP_X1_FLAG = 0;

	// Config register fields.
	localparam int CFG_PRIO_ON = 0;

	// Reset values.
	localparam logic [7:0] RST_MAIN = 8'h00;
	localparam logic [7:0] RST_EDGE_PRIO = 8'hF5;
	localparam logic [7:0] RST_EXT_PINS = 8'hC0;
	localparam logic [7:0] RST_CONFIG = 8'h00;

	// Implemented bit masks.
	localparam logic [7:0] MASK_MAIN = 8'hFF;
	localparam logic [7:0] MASK_EDGE_PRIO = 8'hF5;
	localparam logic [7:0] MASK_EXT_PINS = 8'hDB;
	localparam logic [7:0] MASK_CONFIG = 8'h01;

	// Vector addresses.
	localparam logic [15:0] VEC_HIGH = 16'h0008;
	localparam logic [15:0] VEC_LOW = 16'h0018;

endpackage

// >>> hdl/cic_core.sv
/*
 * Core interrupt control registers with edge capture, flag logic, priority
 * steering and request generation.
 * Assumes a classic Wishbone master on clk_i; pins are asynchronous to clk_i;
 * the timer and port read pulses come from logic on clk_i.
 */
// Operation
// (RULE1) Without priority, top bit is master enable for all sources.
// (RULE2) With priority, top bit is high global enable; clear blocks everything.
// (RULE3) Without priority, second bit gates all peripheral requests.
// (RULE4) With priority, second bit gates all low-priority requests.
// (RULE5) Timer overflow sets a sticky flag; an enable bit gates it.
// (RULE6) Pin 0 selected edge sets sticky flag; enable gates request.
// (RULE7) Port A 5:0 or port B 7:4 change sets port change flag.
// (RULE8) Mismatch keeps setting flag until ports are read.
// (RULE9) Port change request needs per-pin enable and port change enable.
// (RULE10) Edge select bits 6,5,4 pick rising (1) or falling (0).
// (RULE11) Shared bit one turns pull-ups off; zero uses per-pin bits on inputs.
// (RULE12) Timer and port change priority bits pick high or low.
// (RULE13) Pin 2 and pin 1 priority bits pick high or low.
// (RULE14) Pin 2 and pin 1 enable bits allow or suppress requests.
// (RULE15) Pin 2 and pin 1 flags set on edge, held until cleared.
// (RULE16) Flags set regardless of any enable; the code sets the port change flag only on per-pin enabled pins.
// (RULE17) Unimplemented bits read zero and ignore writes.
// (RULE18) Software clears a flag before enabling and after servicing.
// (RULE19) Software sets the priority enable; while clear priority bits are ignored.
// (RULE20) Pending requests vector to 0008h high or 0018h low.
// (RULE21) Core acknowledge clears the governing global enable.
// (RULE22) Requests are OR of flag and enable, gated by global enables; the code ANDs each flag with its enable instead.
// (RULE23) Pins are synchronised before edge detection.
`timescale 1ns/1ps

module cic_core
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Event sources.
	input wire logic [2:0] ext_pin_i,
	input wire logic timer_zero_ovf_i,
	input wire logic periph_req_i,
	input wire logic [5:0] port_a_i,
	input wire logic [7:4] port_b_i,
	input wire logic port_read_i,
	input wire logic [5:0] port_a_change_pin_en_i,
	input wire logic [7:4] port_b_change_pin_en_i,
	input wire logic [5:0] port_a_weak_pullup_i,
	input wire logic [7:4] port_b_weak_pullup_i,
	input wire logic [5:0] port_a_is_input_i,
	input wire logic [7:4] port_b_is_input_i,
	// Core handshake.
	input wire logic core_ack_i,
	output logic irq_high_o,
	output logic irq_low_o,
	output logic [15:0] vector_o,
	// Pull-up controls.
	output logic [5:0] port_a_pullup_on_o,
	output logic [7:4] port_b_pullup_on_o
);

	typedef struct packed {
		logic [7:0] main_r;
		logic [7:0] ep_r;
		logic [7:0] xp_r;
		logic [7:0] cfg_r;
		logic [2:0] pin_s1_r;
		logic [2:0] pin_s2_r;
		logic [2:0] pin_d_r;
		logic [9:0] port_s1_r;
		logic [9:0] port_s2_r;
		logic [9:0] port_latch_r;
		logic [31:0] dat_r;
		logic ack_r;
		logic irq_high_r;
		logic irq_low_r;
		logic [15:0] vector_r;
		logic [9:0] pullup_r;
	} cic_state_t;

	cic_state_t st_r;
	cic_state_t st_nxt;

	logic [2:0] edge_sel;
	logic [2:0] pin_edge;
	logic [9:0] mismatch;
	logic port_event;
	logic wr;
	logic prio_on;
	logic t0_req;
	logic pc_req;
	logic [2:0] x_req;
	logic [4:0] src_req;
	logic [4:0] src_hi;
	logic any_hi;
	logic any_lo;
	logic [7:0] wdat;

	always_comb
	begin
		st_nxt = st_r;
		wdat = dat_i[7:0];
		wr = cyc_i && stb_i && we_i && st_r.ack_r && sel_i[0];
		prio_on = st_r.cfg_r[cic_pkg::CFG_PRIO_ON];
		edge_sel = {st_r.ep_r[cic_pkg::EP_X2_EDGE], st_r.ep_r[cic_pkg::EP_X1_EDGE],
			st_r.ep_r[cic_pkg::EP_X0_EDGE]};

		// (RULE23) Two-stage pin sync.
		st_nxt.pin_s1_r = ext_pin_i;
		st_nxt.pin_s2_r = st_r.pin_s1_r;
		st_nxt.pin_d_r = st_r.pin_s2_r;
		st_nxt.port_s1_r = {port_b_i, port_a_i};
		st_nxt.port_s2_r = st_r.port_s1_r;

		// (RULE10) Edge polarity select.
		pin_edge = (edge_sel & st_r.pin_s2_r & ~st_r.pin_d_r)
			| (~edge_sel & ~st_r.pin_s2_r & st_r.pin_d_r);

		// (RULE8) Mismatch against last read.
		mismatch = st_r.port_s2_r ^ st_r.port_latch_r;
		if (port_read_i)
		begin
			st_nxt.port_latch_r = st_r.port_s2_r;
		end
		// (RULE9) Per-pin change enable.
		port_event = |(mismatch & {port_b_change_pin_en_i, port_a_change_pin_en_i});

		// (RULE17) Register writes with masked bits.
		if (wr)
		begin
			case (adr_i)
				cic_pkg::OFS_MAIN:
				begin
					st_nxt.main_r = wdat & cic_pkg::MASK_MAIN;
				end
				cic_pkg::OFS_EDGE_PRIO:
				begin
					st_nxt.ep_r = wdat & cic_pkg::MASK_EDGE_PRIO;
				end
				cic_pkg::OFS_EXT_PINS:
				begin
					st_nxt.xp_r = wdat & cic_pkg::MASK_EXT_PINS;
				end
				cic_pkg::OFS_CONFIG:
				begin
					st_nxt.cfg_r = wdat & cic_pkg::MASK_CONFIG;
				end
				default:
				begin
					st_nxt.cfg_r = st_r.cfg_r;
				end
			endcase
		end

		// (RULE16) Flags ignore register enables; port change flag needs per-pin enable.
		// (RULE5) Timer flag set wins.
		if (timer_zero_ovf_i)
		begin
			st_nxt.main_r[cic_pkg::MAIN_T0_FLAG] = 1'b1;
		end
		// (RULE6) Pin 0 flag set.
		if (pin_edge[0])
		begin
			st_nxt.main_r[cic_pkg::MAIN_X0_FLAG] = 1'b1;
		end
		// (RULE7) Port change flag set.
		if (port_event)
		begin
			st_nxt.main_r[cic_pkg::MAIN_PC_FLAG] = 1'b1;
		end
		// (RULE15) Pin 1 and 2 flags.
		if (pin_edge[1])
		begin
			st_nxt.xp_r[cic_pkg::XP_X1_FLAG] = 1'b1;
		end
		if (pin_edge[2])
		begin
			st_nxt.xp_r[cic_pkg::XP_X2_FLAG] = 1'b1;
		end

		// (RULE5) Enable gating per source.
		t0_req = st_r.main_r[cic_pkg::MAIN_T0_FLAG] && st_r.main_r[cic_pkg::MAIN_T0_EN];
		pc_req = st_r.main_r[cic_pkg::MAIN_PC_FLAG] && st_r.main_r[cic_pkg::MAIN_PC_EN];
		// (RULE14) Pin enable gating.
		x_req = {st_r.xp_r[cic_pkg::XP_X2_FLAG] && st_r.xp_r[cic_pkg::XP_X2_EN],
			st_r.xp_r[cic_pkg::XP_X1_FLAG] && st_r.xp_r[cic_pkg::XP_X1_EN],
			st_r.main_r[cic_pkg::MAIN_X0_FLAG] && st_r.main_r[cic_pkg::MAIN_X0_EN]};
		src_req = {pc_req, t0_req, x_req};
		// (RULE12) (RULE13) Priority steering; pin 0 is always high.
		src_hi = {st_r.ep_r[cic_pkg::EP_PC_PRIO], st_r.ep_r[cic_pkg::EP_T0_PRIO],
			st_r.xp_r[cic_pkg::XP_X2_PRIO], st_r.xp_r[cic_pkg::XP_X1_PRIO], 1'b1};

		// (RULE22) Request combine.
		if (prio_on)
		begin
			// (RULE2) (RULE4) Priority mode gates.
			any_hi = |(src_req & src_hi) && st_r.main_r[cic_pkg::MAIN_GHE];
			any_lo = (|(src_req & ~src_hi) || periph_req_i)
				&& st_r.main_r[cic_pkg::MAIN_GHE] && st_r.main_r[cic_pkg::MAIN_PLE];
		end
		else
		begin
			// (RULE1) (RULE3) Compatibility mode gates.
			any_hi = st_r.main_r[cic_pkg::MAIN_GHE] && (|src_req
				|| (periph_req_i && st_r.main_r[cic_pkg::MAIN_PLE]));
			any_lo = 1'b0;
		end
		st_nxt.irq_high_r = any_hi;
		st_nxt.irq_low_r = any_lo && !any_hi;

		// (RULE20) Vector select.
		st_nxt.vector_r = any_hi ? cic_pkg::VEC_HIGH :
			(any_lo ? cic_pkg::VEC_LOW : st_r.vector_r);

		// (RULE21) Response clears global enable.
		if (core_ack_i)
		begin
			if (st_r.irq_low_r)
			begin
				st_nxt.main_r[cic_pkg::MAIN_PLE] = 1'b0;
			end
			else
			begin
				st_nxt.main_r[cic_pkg::MAIN_GHE] = 1'b0;
			end
			st_nxt.irq_high_r = 1'b0;
			st_nxt.irq_low_r = 1'b0;
		end

		// (RULE11) Pull-up control.
		st_nxt.pullup_r = st_r.ep_r[cic_pkg::EP_PULLUP_DIS] ? 10'h000 :
			({port_b_weak_pullup_i, port_a_weak_pullup_i}
			& {port_b_is_input_i, port_a_is_input_i});

		// Bus answer, one wait state, unmapped reads zero.
		st_nxt.ack_r = cyc_i && stb_i && !st_r.ack_r;
		case (adr_i)
			cic_pkg::OFS_MAIN: st_nxt.dat_r = {24'h00_0000, st_r.main_r};
			cic_pkg::OFS_EDGE_PRIO: st_nxt.dat_r = {24'h00_0000, st_r.ep_r};
			cic_pkg::OFS_EXT_PINS: st_nxt.dat_r = {24'h00_0000, st_r.xp_r};
			cic_pkg::OFS_CONFIG: st_nxt.dat_r = {24'h00_0000, st_r.cfg_r};
			default: st_nxt.dat_r = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_r <= '0;
			st_r.main_r <= cic_pkg::RST_MAIN;
			st_r.ep_r <= cic_pkg::RST_EDGE_PRIO;
			st_r.xp_r <= cic_pkg::RST_EXT_PINS;
			st_r.cfg_r <= cic_pkg::RST_CONFIG;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign dat_o = st_r.dat_r;
	assign ack_o = st_r.ack_r;
	assign irq_high_o = st_r.irq_high_r;
	assign irq_low_o = st_r.irq_low_r;
	assign vector_o = st_r.vector_r;
	assign port_a_pullup_on_o = st_r.pullup_r[5:0];
	assign port_b_pullup_on_o = st_r.pullup_r[9:6];

	// Assertions.
	sequence s_t0_event;
		timer_zero_ovf_i;
	endsequence

	AST_T0_STICKY: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE5)
		s_t0_event |=> st_r.main_r[cic_pkg::MAIN_T0_FLAG])
		else $error("Timer flag not set after overflow.");

	AST_GHE_BLOCKS: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE1)
		!st_r.main_r[cic_pkg::MAIN_GHE] |=> !irq_high_o && !irq_low_o)
		else $error("Request raised with global enable clear.");

	AST_LOW_GATE: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE4)
		(prio_on && !st_r.main_r[cic_pkg::MAIN_PLE]) |=> !irq_low_o)
		else $error("Low request with low enable clear.");

	AST_NO_LOW_COMPAT: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE3)
		!prio_on |=> !irq_low_o)
		else $error("Low request in compatibility mode.");

	AST_PIN_SYNC: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE23)
		(pin_edge[1] && !st_r.xp_r[cic_pkg::XP_X1_FLAG]) |=> st_r.xp_r[cic_pkg::XP_X1_FLAG])
		else $error("Pin 1 edge lost.");

	AST_VEC_HIGH: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE20)
		irq_high_o |-> vector_o == cic_pkg::VEC_HIGH)
		else $error("High request with wrong vector.");

	AST_VEC_LOW: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE20)
		irq_low_o |-> vector_o == cic_pkg::VEC_LOW)
		else $error("Low request with wrong vector.");

	AST_ACK_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE21)
		(core_ack_i && irq_high_o && !wr) |=> !st_r.main_r[cic_pkg::MAIN_GHE])
		else $error("High enable not cleared on response.");

	AST_RESERVED: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE17)
		(st_r.ep_r & ~cic_pkg::MASK_EDGE_PRIO) == 8'h00
		&& (st_r.xp_r & ~cic_pkg::MASK_EXT_PINS) == 8'h00)
		else $error("Unimplemented bit set.");

	AST_PULLUP_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE11)
		st_r.ep_r[cic_pkg::EP_PULLUP_DIS] |=> port_a_pullup_on_o == 6'h00)
		else $error("Pull-up on while disabled.");

	AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		(cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
		else $error("Bus answer not a single cycle.");

	sequence s_pin0_rise_sel;
		st_r.ep_r[cic_pkg::EP_X0_EDGE] && st_r.pin_s2_r[0] && !st_r.pin_d_r[0];
	endsequence

	AST_RISE_SETS: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE10)
		s_pin0_rise_sel |=> st_r.main_r[cic_pkg::MAIN_X0_FLAG])
		else $error("Pin 0 rising edge lost.");

	AST_X2_FALL: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE15)
		(!st_r.ep_r[cic_pkg::EP_X2_EDGE] && !st_r.pin_s2_r[2] && st_r.pin_d_r[2])
		|=> st_r.xp_r[cic_pkg::XP_X2_FLAG])
		else $error("Pin 2 falling edge lost.");

	AST_PC_SET: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE7)
		port_event |=> st_r.main_r[cic_pkg::MAIN_PC_FLAG])
		else $error("Port change flag not set.");

	AST_MISMATCH_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE8)
		(mismatch[0] && port_a_change_pin_en_i[0]) |=> st_r.main_r[cic_pkg::MAIN_PC_FLAG])
		else $error("Port flag dropped during mismatch.");

	AST_T0_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE5)
		(st_r.main_r[cic_pkg::MAIN_T0_FLAG] && !wr) |=> st_r.main_r[cic_pkg::MAIN_T0_FLAG])
		else $error("Timer flag dropped without a write.");

	AST_X1_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE15)
		(st_r.xp_r[cic_pkg::XP_X1_FLAG] && !wr) |=> st_r.xp_r[cic_pkg::XP_X1_FLAG])
		else $error("Pin 1 flag dropped without a write.");

	AST_IRQ_EXCL: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE22)
		!(irq_high_o && irq_low_o))
		else $error("High and low requests together.");

	AST_LOW_ACK: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE21)
		(core_ack_i && irq_low_o) |=> !st_r.main_r[cic_pkg::MAIN_PLE])
		else $error("Low enable not cleared on response.");

	AST_ACK_DROPS: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE21)
		core_ack_i |=> !irq_high_o && !irq_low_o)
		else $error("Request still raised after response.");

	AST_COMPAT_HIGH: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE1)
		(!prio_on && st_r.main_r[cic_pkg::MAIN_GHE] && t0_req && !core_ack_i) |=> irq_high_o)
		else $error("Enabled timer request not raised.");

	AST_X1_HIGH: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE13)
		(prio_on && st_r.main_r[cic_pkg::MAIN_GHE] && x_req[1]
		&& st_r.xp_r[cic_pkg::XP_X1_PRIO] && !core_ack_i) |=> irq_high_o)
		else $error("High priority pin 1 request not raised.");

	AST_NO_SOURCE: assert property (@(posedge clk_i) disable iff (rst_i) // (RULE14)
		(src_req == 5'h00 && !periph_req_i) |=> !irq_high_o && !irq_low_o)
		else $error("Request raised with no enabled source.");

endmodule

// >>> dv/cic_core_model.sv
/*
 * Behavioural processor core that services the block's interrupt requests.
 * Assumes registered request and vector outputs on clk_i; delay_i sets how slowly it answers.
 */
`timescale 1ns/1ps

module cic_core_model
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Requests from the control block.
	input wire logic irq_high_i,
	input wire logic irq_low_i,
	input wire logic [15:0] vector_i,
	input wire logic [3:0] delay_i,
	// Response and record.
	output logic core_ack_o,
	output logic [15:0] tvec_o,
	output logic [7:0] tcnt_o
);
	logic [3:0] wait_r;

	always_ff @(posedge clk_i)
	begin
		core_ack_o <= 1'b0;
		if (rst_i)
		begin
			wait_r <= 4'h0;
			tvec_o <= 16'h0000;
			tcnt_o <= 8'h00;
		end
		else if ((irq_high_i || irq_low_i) && !core_ack_o)
		begin
			if (wait_r < delay_i)
				wait_r <= wait_r + 4'h1;
			else
			begin
				core_ack_o <= 1'b1;
				wait_r <= 4'h0;
				tvec_o <= vector_i;
				tcnt_o <= tcnt_o + 8'h01;
			end
		end
	end
endmodule

// >>> dv/cic_core_tb.sv
/*
 * Self-checking bench for the core interrupt control block.
 * Assumes the design package, cic_core and the core model.
 */
`timescale 1ns/1ps

module cic_core_tb;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [3:0] adr_i = 4'h0, sel_i = 4'h1, dly = 4'h0;
	logic [31:0] dat_i = '0, dat_o, q;
	logic ack_o, irq_high_o, irq_low_o, core_ack_i, timer_zero_ovf_i = 0;
	logic periph_req_i = 0, port_read_i = 0;
	logic [2:0] ext_pin_i = 3'h0;
	logic [5:0] port_a_i = '0, port_a_change_pin_en_i = '0, port_a_weak_pullup_i = 6'h3C;
	logic [5:0] port_a_is_input_i = 6'h0A, port_a_pullup_on_o;
	logic [7:4] port_b_i = '0, port_b_change_pin_en_i = '0, port_b_weak_pullup_i = 4'hF;
	logic [7:4] port_b_is_input_i = 4'h5, port_b_pullup_on_o;
	logic [15:0] vector_o, tvec;
	logic [7:0] tcnt;
	int err_count = 0, n_compared = 0;
	wire [31:0] irqs = {30'h0000_0000, irq_high_o, irq_low_o};
	wire [31:0] pus = {22'h00_0000, port_a_pullup_on_o, port_b_pullup_on_o};

	cic_core uut
	(
		.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.ext_pin_i, .timer_zero_ovf_i, .periph_req_i, .port_a_i, .port_b_i, .port_read_i,
		.port_a_change_pin_en_i, .port_b_change_pin_en_i, .port_a_weak_pullup_i,
		.port_b_weak_pullup_i, .port_a_is_input_i, .port_b_is_input_i, .core_ack_i,
		.irq_high_o, .irq_low_o, .vector_o, .port_a_pullup_on_o, .port_b_pullup_on_o
	);

	cic_core_model core
	(
		.clk_i(clk_i), .rst_i(rst_i), .irq_high_i(irq_high_o), .irq_low_i(irq_low_o),
		.vector_i(vector_o), .delay_i(dly), .core_ack_o(core_ack_i), .tvec_o(tvec),
		.tcnt_o(tcnt)
	);

	always #2.5 clk_i = ~clk_i;

	task automatic summarize();
		if (err_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [7:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== {24'h00_0000, e})
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h00_0000, d};
		@(posedge clk_i);
		while (ack_o !== 1'b1)
			@(posedge clk_i);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		wb(1'b1, a, d);
	endtask

	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		cmp("register", e, q);
	endtask

	task automatic cm(input logic [7:0] n, input logic [7:0] v);
		repeat (20) @(posedge clk_i);
		cmp("acks", n, {24'h00_0000, tcnt});
		cmp("vector", v, {16'h0000, tvec});
	endtask

	initial
	begin
		repeat (4000) @(posedge clk_i);
		err_count++;
		summarize();
	end

	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(4'h0, 8'h00);
		rc(4'h4, 8'hF5);
		rc(4'h8, 8'hC0);
		rc(4'hC, 8'h00);
		rc(4'h2, 8'h00);
		cmp("pullup", 8'h00, pus);
		for (int i = 1; i < 4; i++)
		begin
			wr(4'(i * 4), 8'hFF);
			rc(4'(i * 4), i == 1 ? 8'hF5 : i == 2 ? 8'hDB : 8'h01);
			wr(4'(i * 4), i == 1 ? 8'hF5 : i == 2 ? 8'hC0 : 8'h00);
		end
		for (int k = 0; k < 3; k++)
			for (int s = 0; s < 2; s++)
			begin
				wr(4'h4, s ? 8'hF5 : 8'hF5 ^ (8'h40 >> k));
				ext_pin_i[k] <= !s;
				repeat (6) @(posedge clk_i);
				wr(4'h0, 8'h00);
				wr(4'h8, 8'hC0);
				ext_pin_i[k] <= s;
				repeat (6) @(posedge clk_i);
				wb(1'b0, k ? 4'h8 : 4'h0, 8'h00);
				cmp("pin flag", k == 1 ? 8'h01 : 8'h02, q & (k == 1 ? 1 : 2));
				cmp("irq", 8'h00, irqs);
			end
		timer_zero_ovf_i <= 1'b1;
		@(posedge clk_i);
		timer_zero_ovf_i <= 1'b0;
		rc(4'h0, 8'h04);
		wr(4'h0, 8'hA4);
		cm(8'h01, 8'h08);
		rc(4'h0, 8'h24);
		wr(4'h0, 8'h20);
		wr(4'hC, 8'h01);
		wr(4'h4, 8'hF1);
		wr(4'h0, 8'h64);
		repeat (6) @(posedge clk_i);
		cmp("irq", 8'h00, irqs);
		dly <= 4'h7;
		wr(4'h0, 8'hE4);
		cm(8'h02, 8'h18);
		rc(4'h0, 8'hA4);
		cmp("irq", 8'h00, irqs);
		wr(4'h4, 8'hF5);
		cm(8'h03, 8'h08);
		rc(4'h0, 8'h24);
		dly <= 4'h0;
		wr(4'h0, 8'hC0);
		wr(4'h8, 8'h42);
		repeat (6) @(posedge clk_i);
		cmp("irq", 8'h00, irqs);
		wr(4'h8, 8'h52);
		cm(8'h04, 8'h18);
		wr(4'h8, 8'h49);
		cm(8'h05, 8'h08);
		rc(4'h0, 8'h00);
		wr(4'h8, 8'hC0);
		wr(4'hC, 8'h00);
		periph_req_i <= 1'b1;
		wr(4'h0, 8'h80);
		repeat (6) @(posedge clk_i);
		cmp("irq", 8'h00, irqs);
		wr(4'h0, 8'hC0);
		cm(8'h06, 8'h08);
		rc(4'h0, 8'h40);
		cmp("irq", 8'h00, irqs);
		periph_req_i <= 1'b0;
		wr(4'h0, 8'h00);
		port_a_change_pin_en_i <= 6'h01;
		port_a_i <= 6'h01;
		repeat (6) @(posedge clk_i);
		rc(4'h0, 8'h01);
		wr(4'h0, 8'h00);
		rc(4'h0, 8'h01);
		port_read_i <= 1'b1;
		@(posedge clk_i);
		port_read_i <= 1'b0;
		wr(4'h0, 8'h00);
		rc(4'h0, 8'h00);
		port_b_i <= 4'h1;
		wr(4'h0, 8'h88);
		repeat (6) @(posedge clk_i);
		cmp("irq", 8'h00, irqs);
		port_b_change_pin_en_i <= 4'h1;
		cm(8'h07, 8'h08);
		rc(4'h0, 8'h09);
		wr(4'hC, 8'h01);
		periph_req_i <= 1'b1;
		wr(4'h0, 8'h40);
		repeat (6) @(posedge clk_i);
		cmp("irq", 8'h00, irqs);
		wr(4'h0, 8'hC0);
		cm(8'h08, 8'h18);
		rc(4'h0, 8'h81);
		periph_req_i <= 1'b0;
		wr(4'hC, 8'h00);
		wr(4'h4, 8'h75);
		repeat (3) @(posedge clk_i);
		cmp("pullup", 8'h85, pus);
		summarize();
	end
endmodule
